// ### include/otp_seq_pkg.sv
// Package: register map, command values and timing constants for the OTP burn sequencer
package otp_seq_pkg;
  // Register offsets
  localparam logic [7:0] SHADOW_FIRST     = 8'h00;
  localparam logic [7:0] SHADOW_LAST      = 8'h1e;
  localparam logic [7:0] SIGNATURE_ADDR   = 8'h1e;
  localparam logic [7:0] CORE_CTRL_ADDR   = 8'h23;
  localparam logic [7:0] KEY_FIRST_ADDR   = 8'h62;
  localparam logic [7:0] KEY_SECOND_ADDR  = 8'h63;
  localparam logic [7:0] ANGLE_LO_ADDR    = 8'h40;
  localparam logic [7:0] ANGLE_HI_ADDR    = 8'h41;
  localparam logic [7:0] STATUS_ADDR      = 8'h42;
  // Command values
  localparam logic [7:0] CTRL_CORE_RESET  = 8'h20;
  localparam logic [7:0] CTRL_GUARD_BAND  = 8'h40;
  localparam logic [7:0] CTRL_NORMAL      = 8'h00;
  localparam logic [7:0] KEY_FIRST_VAL    = 8'h70;
  localparam logic [7:0] KEY_SECOND_VAL   = 8'h51;
  // Field positions
  localparam int LOCK_REG_IDX = 32'h0000_001d;
  localparam int LOCK_BIT     = 0;
  localparam int STAT_BURNING = 0;
  localparam int STAT_REFRESH = 1;
  localparam int STAT_FUSED   = 2;
  localparam int STAT_GUARD   = 3;
  localparam int STAT_FUNC    = 4;
  localparam int STAT_KEYARM  = 5;
  // Timing
  localparam int CLK_MHZ      = 50;
  localparam int BURN_TIME_MS = 10;
  localparam int REFR_TIME_MS = 5;
  localparam int BURN_CYCLES  = BURN_TIME_MS * 1000 * CLK_MHZ;
  localparam int REFR_CYCLES  = REFR_TIME_MS * 1000 * CLK_MHZ;
  localparam int SHADOW_DEPTH = 31;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_BURN  = 4'b0010,
    ST_REFR  = 4'b0100,
    ST_DONE  = 4'b1000
  } otp_state_t;
endpackage : otp_seq_pkg

// ### logic/otp_seq.sv
// OTP burn and verify sequencer with register shadow and fuse array
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module otp_seq #(
  parameter int BURN_CNT = otp_seq_pkg::BURN_CYCLES,
  parameter int REFR_CNT = otp_seq_pkg::REFR_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Sensor core side
  input  wire logic [15:0] measured_angle,
  output logic             core_reset,
  output logic             guard_band,
  output logic             func_mode,
  output logic             comm_mode
);
  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]  shadow_reg [otp_seq_pkg::SHADOW_DEPTH];
  logic [7:0]  fuse_reg   [otp_seq_pkg::SHADOW_DEPTH];
  logic [7:0]  ctrl_reg;
  logic        key_arm_reg;
  logic        fused_reg;
  logic        started_reg;
  logic        func_reg;
  logic        comm_reg;
  logic        guard_reg;
  logic [31:0] cnt_reg;
  logic [7:0]  rdata_reg;
  logic        core_reset_reg;
  otp_seq_pkg::otp_state_t state_reg;
  otp_seq_pkg::otp_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire in_shadow  = addr <= otp_seq_pkg::SHADOW_LAST;
  wire busy       = state_reg != otp_seq_pkg::ST_IDLE;
  // Writes are dropped while fusing or reloading, and in functional mode
  wire wr_ok      = wr && !busy && comm_reg;
  wire wr_shadow  = wr_ok && in_shadow;
  wire wr_ctrl    = wr_ok && (addr == otp_seq_pkg::CORE_CTRL_ADDR);
  wire wr_key1    = wr_ok && (addr == otp_seq_pkg::KEY_FIRST_ADDR);
  wire wr_key2    = wr_ok && (addr == otp_seq_pkg::KEY_SECOND_ADDR);
  // Burn needs the first key as the immediately preceding write; a repeat burn is refused until reset, and after it too when the lock bit is fused
  wire key1_hit   = wr_key1 && (wdata == otp_seq_pkg::KEY_FIRST_VAL);
  wire burn_go    = wr_key2 && (wdata == otp_seq_pkg::KEY_SECOND_VAL) && key_arm_reg
                    && !fused_reg;
  wire reload_go  = wr_ctrl && fused_reg &&
                    ((wdata == otp_seq_pkg::CTRL_GUARD_BAND) ||
                     (wdata == otp_seq_pkg::CTRL_NORMAL));
  wire cnt_done   = cnt_reg == 32'h0000_0000;
  // Reload lands on the last wait cycle, while writes are still refused
  wire reload_done = (state_reg == otp_seq_pkg::ST_REFR) && cnt_done;
  wire [7:0] status = {2'h0, key_arm_reg, func_reg, ctrl_reg == otp_seq_pkg::CTRL_GUARD_BAND,
                       fused_reg, state_reg == otp_seq_pkg::ST_REFR,
                       state_reg == otp_seq_pkg::ST_BURN};

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    if (in_shadow) begin
      rd_mux = shadow_reg[addr[4:0]];
    end else if (addr == otp_seq_pkg::CORE_CTRL_ADDR) begin
      rd_mux = ctrl_reg;
    end else if (addr == otp_seq_pkg::ANGLE_LO_ADDR) begin
      rd_mux = measured_angle[7:0];
    end else if (addr == otp_seq_pkg::ANGLE_HI_ADDR) begin
      rd_mux = measured_angle[15:8];
    end else if (addr == otp_seq_pkg::STATUS_ADDR) begin
      rd_mux = status;
    end else begin
      rd_mux = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      otp_seq_pkg::ST_IDLE: begin
        if (burn_go) begin
          state_next = otp_seq_pkg::ST_BURN;
        end else if (reload_go) begin
          state_next = otp_seq_pkg::ST_REFR;
        end
      end
      otp_seq_pkg::ST_BURN: begin
        if (cnt_done) begin
          state_next = otp_seq_pkg::ST_IDLE;
        end
      end
      otp_seq_pkg::ST_REFR: begin
        if (cnt_done) begin
          state_next = otp_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = otp_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= otp_seq_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Wait counter for fuse and reload phases
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0000_0000;
    end else if (burn_go) begin
      cnt_reg <= 32'(BURN_CNT - 1);
    end else if (reload_go) begin
      cnt_reg <= 32'(REFR_CNT - 1);
    end else if (!cnt_done) begin
      cnt_reg <= cnt_reg - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, key and core-reset flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg       <= otp_seq_pkg::CTRL_NORMAL;
      key_arm_reg    <= 1'b0;
      core_reset_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata;
      end
      core_reset_reg <= wr_ctrl && (wdata == otp_seq_pkg::CTRL_CORE_RESET);
      if (wr) begin
        key_arm_reg <= key1_hit;
      end
    end
  end

  // Fuse array written once at end of burn; it survives reset as nonvolatile
  always_ff @(posedge clk_sys) begin
    if (state_reg == otp_seq_pkg::ST_BURN && cnt_done) begin
      fuse_reg <= shadow_reg;
    end
  end

  // Fused flag: set at burn completion; cleared by reset and again in the first cycle after it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fused_reg <= 1'b0;
    end else if (state_reg == otp_seq_pkg::ST_BURN && cnt_done) begin
      fused_reg <= 1'b1;
    end else if (!started_reg) begin
      fused_reg <= 1'b0;
    end
  end

  // Start-up: first cycle after reset reads the lock fuse to pick the mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      started_reg <= 1'b0;
      func_reg    <= 1'b0;
      comm_reg    <= 1'b0;
    end else if (!started_reg) begin
      started_reg <= 1'b1;
      func_reg    <= fuse_reg[otp_seq_pkg::LOCK_REG_IDX][otp_seq_pkg::LOCK_BIT] === 1'b1;
      comm_reg    <= fuse_reg[otp_seq_pkg::LOCK_REG_IDX][otp_seq_pkg::LOCK_BIT] !== 1'b1;
    end
  end

  // Shadow: software writes, or bulk copy from fuses at reload end (the copy wins over a write)
  always_ff @(posedge clk_sys) begin
    if (reload_done) begin
      shadow_reg <= fuse_reg;
    end else if (wr_shadow) begin
      shadow_reg[addr[4:0]] <= wdata;
    end
  end

  // Read data, one cycle after the strobe only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata      = rdata_reg;
  assign core_reset = core_reset_reg;
  assign guard_band = guard_reg;
  assign func_mode  = func_reg;
  assign comm_mode  = comm_reg;

  // Guard-band select held as a register output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      guard_reg <= 1'b0;
    end else begin
      guard_reg <= ctrl_reg == otp_seq_pkg::CTRL_GUARD_BAND;
    end
  end
endmodule : otp_seq

// ### dv/angle_src.sv
// Sensor-core stand-in: magnet held at the start or stop position
`timescale 1ns/1ns
module angle_src #(
  parameter logic [15:0] START_ANGLE = 16'h0123,
  parameter logic [15:0] STOP_ANGLE  = 16'h2fed
) (
  // Magnet position
  input  wire logic        at_stop,
  // Angle towards the block
  output logic      [15:0] measured_angle
);
  // Magnet still at one end of travel, so the angle never drifts mid-read
  assign measured_angle = at_stop ? STOP_ANGLE : START_ANGLE;
endmodule : angle_src

// ### dv/otp_seq_asserts.sv
// Checker: port-level properties of the OTP sequencer
`timescale 1ns/1ns
module otp_seq_asserts (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  // Core side
  input wire logic [15:0] measured_angle,
  input wire logic        core_reset,
  input wire logic        guard_band,
  input wire logic        func_mode,
  input wire logic        comm_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Request shapes
  sequence ctl_wr(logic [7:0] v);
    wr && addr == otp_seq_pkg::CORE_CTRL_ADDR && wdata == v && comm_mode;
  endsequence
  sequence key_pair;
    wr && addr == otp_seq_pkg::KEY_FIRST_ADDR && wdata == otp_seq_pkg::KEY_FIRST_VAL
      && comm_mode ##1
    wr && addr == otp_seq_pkg::KEY_SECOND_ADDR && wdata == otp_seq_pkg::KEY_SECOND_VAL;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  core_pulse_a: assert property (ctl_wr(8'h20) |=> core_reset ##1 !core_reset)
    else $error("core reset pulse wrong");
  angle_read_a: assert property (rd && addr == otp_seq_pkg::ANGLE_LO_ADDR
    |=> rdata == $past(measured_angle[7:0])) else $error("angle byte wrong");
  key_burn_a: assert property (key_pair ##1 (rd && addr == otp_seq_pkg::STATUS_ADDR)
    |=> rdata[0]) else $error("burn not started by key pair");
  guard_on_a: assert property (ctl_wr(8'h40) |-> ##[1:2] guard_band)
    else $error("guard band not selected");
  guard_off_a: assert property (ctl_wr(8'h00) |-> ##[1:2] !guard_band)
    else $error("guard band not released");
  guard_cause_a: assert property ($changed(guard_band)
    |-> $past(wr && addr == otp_seq_pkg::CORE_CTRL_ADDR)
    || $past(wr && addr == otp_seq_pkg::CORE_CTRL_ADDR, 2)) else $error("guard band moved");
  mode_excl_a: assert property (!(func_mode && comm_mode))
    else $error("both modes active");
  func_hold_a: assert property (func_mode |=> func_mode) else $error("func mode lost");
  comm_hold_a: assert property (comm_mode |=> comm_mode) else $error("comm mode lost");
endmodule : otp_seq_asserts

bind otp_seq otp_seq_asserts chk_i (.clk_sys, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .measured_angle, .core_reset, .guard_band, .func_mode, .comm_mode);

// ### dv/tb_otp_seq.sv
// Testbench: calibrate, load, burn, verify and restart the OTP sequencer
`timescale 1ns/1ns
module tb_otp_seq;
  localparam int BURN = 20;
  localparam int REFR = 10;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        at_stop = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] measured_angle;
  logic        core_reset;
  logic        guard_band;
  logic        func_mode;
  logic        comm_mode;
  logic [7:0]  sh [0:29];
  logic [7:0]  sig;
  logic [7:0]  v;
  int          failures = 0;
  int          n_checks = 0;
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  otp_seq #(.BURN_CNT(BURN), .REFR_CNT(REFR)) uut (.clk_sys, .rst, .addr, .wdata, .wr,
    .rd, .rdata, .measured_angle, .core_reset, .guard_band, .func_mode, .comm_mode);
  angle_src core_model (.at_stop, .measured_angle);
  ////////////////////////////////////////////////////////////////////////////
  // Bus helpers and compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : w
  task automatic r(input logic [7:0] a);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : r
  // Signature over bytes 2..29, shift left with feedback 0x1d
  function automatic logic [7:0] misr();
    logic [7:0] m;
    m = 8'h00;
    for (int i = 2; i < 30; i++) begin
      m = {m[6:0], 1'b0} ^ sh[i] ^ (m[7] ? 8'h1d : 8'h00);
    end
    return m;
  endfunction : misr
  task automatic rb();
    for (int a = 2; a < 31; a++) begin
      r(8'(a));
      chk(v, (a == 30) ? sig : sh[a]);
    end
  endtask : rb
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_calib();
    chk({6'h0, func_mode, comm_mode}, 8'h01);
    w(otp_seq_pkg::CORE_CTRL_ADDR, otp_seq_pkg::CTRL_CORE_RESET);
    #1 chk({7'h0, core_reset}, 8'h01);
    r(otp_seq_pkg::ANGLE_LO_ADDR);
    chk(v, 8'h23);
    at_stop <= 1'b1;
    r(otp_seq_pkg::ANGLE_HI_ADDR);
    chk(v, 8'h2f);
    $display("calib test done");
  endtask : t_calib
  // Lock bit sits in bit 0 of byte 29; the signature byte is stored last
  task automatic t_load();
    for (int a = 2; a < 30; a++) begin
      sh[a] = 8'(a * 37) | ((a == 29) ? 8'h01 : 8'h00);
      w(8'(a), sh[a]);
    end
    sig = misr();
    w(otp_seq_pkg::SIGNATURE_ADDR, sig);
    rb();
    $display("load test done");
  endtask : t_load
  // Key 2 alone, and key 1 disarmed by another write, must not burn
  task automatic t_keys();
    w(otp_seq_pkg::KEY_SECOND_ADDR, otp_seq_pkg::KEY_SECOND_VAL);
    w(otp_seq_pkg::KEY_FIRST_ADDR, otp_seq_pkg::KEY_FIRST_VAL);
    r(otp_seq_pkg::STATUS_ADDR);
    chk(v & 8'h21, 8'h20);
    w(8'h02, sh[2]);
    w(otp_seq_pkg::KEY_SECOND_ADDR, otp_seq_pkg::KEY_SECOND_VAL);
    r(otp_seq_pkg::STATUS_ADDR);
    chk(v & 8'h27, 8'h00);
    r(otp_seq_pkg::KEY_FIRST_ADDR);
    chk(v, 8'h00);
    r(8'h80);
    chk(v, 8'h00);
    $display("key refusal test done");
  endtask : t_keys
  task automatic t_burn();
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= otp_seq_pkg::KEY_FIRST_ADDR;
    wdata <= otp_seq_pkg::KEY_FIRST_VAL;
    @(posedge clk_sys);
    addr <= otp_seq_pkg::KEY_SECOND_ADDR;
    wdata <= otp_seq_pkg::KEY_SECOND_VAL;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= otp_seq_pkg::STATUS_ADDR;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(rdata & 8'h05, 8'h01);
    repeat (BURN - 6) @(posedge clk_sys);
    r(otp_seq_pkg::STATUS_ADDR);
    chk(v & 8'h05, 8'h01);
    repeat (4) @(posedge clk_sys);
    r(otp_seq_pkg::STATUS_ADDR);
    chk(v & 8'h05, 8'h04);
    $display("burn test done");
  endtask : t_burn
  task automatic t_verify(input logic [7:0] ctl);
    w(otp_seq_pkg::SIGNATURE_ADDR, 8'h00);
    w(otp_seq_pkg::CORE_CTRL_ADDR, ctl);
    r(otp_seq_pkg::SIGNATURE_ADDR);
    chk(v, 8'h00);
    chk({7'h0, guard_band}, {7'h0, ctl == otp_seq_pkg::CTRL_GUARD_BAND});
    repeat (REFR + 2) @(posedge clk_sys);
    rb();
    $display("verify test done");
  endtask : t_verify
  // Restart with the lock fused: functional mode, writes no longer land
  task automatic t_restart();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({6'h0, func_mode, comm_mode}, 8'h02);
    w(8'h02, ~sh[2]);
    r(8'h02);
    chk(v, sh[2]);
    $display("restart test done");
  endtask : t_restart
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_calib();
    t_load();
    t_keys();
    // Programming path only; the key pair is never sent after a mismatch
    if (failures == 0) begin
      t_burn();
      t_verify(otp_seq_pkg::CTRL_GUARD_BAND);
      t_verify(otp_seq_pkg::CTRL_NORMAL);
      t_restart();
    end
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    report_and_stop();
  end
endmodule : tb_otp_seq
